/* include/hdbi_defines.vh */
// Constants for the host and DMA bus interface
`ifndef HDBI_DEFINES_VH
`define HDBI_DEFINES_VH

// ----------------------------------------------------------------
// Register address map as seen by the core
// ----------------------------------------------------------------
`define HDBI_ADDR_W 4
`define HDBI_FIFO_ADDR 4'h2
`define HDBI_INT_STATUS_ADDR 4'h5

// ----------------------------------------------------------------
// Byte lane codes, bit 1 is the upper lane, bit 0 the lower lane
// ----------------------------------------------------------------
`define HDBI_LANES_NONE 2'h0
`define HDBI_LANES_LOW 2'h1
`define HDBI_LANES_HIGH 2'h2
`define HDBI_LANES_BOTH 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HDBI_RST_BYTE 8'h00
`define HDBI_RST_WORD 16'h0000
`define HDBI_RST_ADDR 4'h0

`endif

/* rtl/hdbi_lane_parity.v */
// Odd parity generator for the two byte lanes of the DMA word bus
`timescale 1ns/10ps

module hdbi_lane_parity (
    input wire [15:0] data,
    output wire [1:0] odd_par
);

    // ----------------------------------------------------------------
    // One parity bit per byte lane
    // ----------------------------------------------------------------
    assign odd_par[1] = ~(^data[15:8]);
    assign odd_par[0] = ~(^data[7:0]);

endmodule // hdbi_lane_parity

/* rtl/hdbi_addr_latch.v */
// Address latch for the multiplexed processor port
`timescale 1ns/10ps
`include "hdbi_defines.vh"

module hdbi_addr_latch (
    input wire clk,
    input wire rstn,
    input wire enable,
    input wire latch_strobe,
    input wire [3:0] port_low,
    output reg [3:0] addr_q
);

    reg strobe_q;

    // ----------------------------------------------------------------
    // Capture on the high-to-low transition of the latch strobe
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strobe_q <= 1'b0;
            addr_q <= `HDBI_RST_ADDR;
        end else begin
            strobe_q <= latch_strobe;
            if (enable && strobe_q && !latch_strobe) begin
                addr_q <= port_low;
            end
        end
    end

endmodule // hdbi_addr_latch

/* rtl/hdbi_host_port.v */
// Processor and DMA bus port: register access, FIFO transfers, request and interrupt
`timescale 1ns/10ps
`include "hdbi_defines.vh"

// Contract
// - Dual bus: processor port takes register accesses while DMA runs.
// - Multiplexed: port carries address and data; otherwise data, address on pins.
// - Single bus: registers on low DMA byte, FIFO DMA on all sixteen bits.
// - One odd parity bit per DMA byte lane.
// - Multiplexed address captured on latch strobe falling edge.
// - Upper address pins: bits 3,2, or latch strobe and DMA read when multiplexed.
// - Byte control lanes: 00 low, 01 none, 10 both, 11 high.
// - Byte control only when multiplexed, in mode 2 with option bit; else low pins ignored when multiplexed, address bits 1,0 otherwise.
// - DMA write strobe under acknowledge loads bus word into FIFO.
// - Chip select reaches any register; acknowledge reaches only the FIFO.
// - Bus driven only while read strobe with select or acknowledge.
// - Write strobe with chip select writes the addressed register.
// - Interrupt output changes on the rising clock edge, or at once on reset.
// - Interrupt cleared by status read, reset, software reset; not bus reset.
// - Interrupt output has no mask.
// - DMA request follows FIFO data available or room available.
module hdbi_host_port (
    input wire clk,
    input wire rstn,
    input wire cfg_dual_bus,
    input wire cfg_mux_mode,
    input wire cfg_host_mode2,
    input wire cfg_byte_ctrl,
    input wire dma_dir_to_host,
    input wire fifo_has_unit,
    input wire fifo_has_room,
    input wire [7:0] processor_addr_data_port_in,
    output reg [7:0] processor_addr_data_port_out,
    output reg processor_addr_data_port_oe,
    input wire addr3_or_latch_strobe_pin,
    input wire addr2_or_dma_read_pin,
    input wire addr1_or_high_enable_pin,
    input wire addr0_or_low_select_pin,
    input wire chip_select_n,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire dma_acknowledge_n,
    input wire dma_write_strobe_n,
    input wire [15:0] dma_word_bus_in,
    output reg [15:0] dma_word_bus_out,
    output reg [1:0] dma_word_bus_oe,
    input wire upper_lane_parity_in,
    input wire lower_lane_parity_in,
    output reg upper_lane_parity_out,
    output reg lower_lane_parity_out,
    output reg upper_lane_parity_oe,
    output reg lower_lane_parity_oe,
    output reg dma_request,
    output reg interrupt_n_out,
    output reg interrupt_n_oe,
    output reg [3:0] reg_addr,
    output reg reg_wr_pulse,
    output reg [7:0] reg_wdata,
    output reg reg_rd_pulse,
    input wire [7:0] reg_rdata,
    output reg fifo_wr_pulse,
    output reg [15:0] fifo_wdata,
    output reg [1:0] fifo_wpar,
    output reg [1:0] fifo_lanes,
    output reg fifo_rd_pulse,
    input wire [15:0] fifo_rdata,
    input wire int_event,
    input wire sw_chip_reset
);

    // ----------------------------------------------------------------
    // Lane decode from high-byte enable and low-byte select
    // ----------------------------------------------------------------
    function [1:0] hdbi_lanes;
        input high_byte_enable;
        input low_byte_select;
        begin
            case ({high_byte_enable, low_byte_select})
                2'h0: hdbi_lanes = `HDBI_LANES_LOW;
                2'h1: hdbi_lanes = `HDBI_LANES_NONE;
                2'h2: hdbi_lanes = `HDBI_LANES_BOTH;
                default: hdbi_lanes = `HDBI_LANES_HIGH;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin decode
    // ----------------------------------------------------------------
    wire single_bus;
    wire [3:0] latched_addr;
    wire [3:0] addr_now;
    wire dma_read_strobe_n;
    wire cs_act;
    wire dma_acknowledge_n_act;
    wire reg_rd_now;
    wire reg_wr_now;
    wire dma_rd_now;
    wire dma_wr_now;
    wire byte_ctrl;
    wire [1:0] lanes_now;
    wire [7:0] reg_bus_in;

    assign single_bus = ~cfg_dual_bus;

    hdbi_addr_latch u_addr_latch (
        .clk(clk),
        .rstn(rstn),
        .enable(cfg_mux_mode),
        .latch_strobe(addr3_or_latch_strobe_pin),
        .port_low(processor_addr_data_port_in[3:0]),
        .addr_q(latched_addr)
    );

    // Multiplexed address comes from the latch, else from the four pins
    assign addr_now = cfg_mux_mode ? latched_addr :
        {addr3_or_latch_strobe_pin, addr2_or_dma_read_pin,
         addr1_or_high_enable_pin, addr0_or_low_select_pin};

    // Pin 2 is the DMA read strobe when multiplexed
    assign dma_read_strobe_n = cfg_mux_mode ? addr2_or_dma_read_pin : read_strobe_n;

    assign cs_act = ~chip_select_n;
    // Single bus: select takes precedence if the host breaks exclusivity
    assign dma_acknowledge_n_act = ~dma_acknowledge_n & ~(single_bus & cs_act);

    assign reg_rd_now = cs_act & ~read_strobe_n;
    assign reg_wr_now = cs_act & ~write_strobe_n;
    assign dma_rd_now = dma_acknowledge_n_act & ~dma_read_strobe_n;
    assign dma_wr_now = dma_acknowledge_n_act & ~dma_write_strobe_n;

    // When multiplexed, low address pins only matter with byte control; otherwise they are address bits 1,0
    assign byte_ctrl = cfg_mux_mode & cfg_host_mode2 & cfg_byte_ctrl;
    assign lanes_now = byte_ctrl ?
        hdbi_lanes(addr1_or_high_enable_pin, addr0_or_low_select_pin) :
        `HDBI_LANES_BOTH;

    // Register data on the low DMA byte in single bus, else processor port
    assign reg_bus_in = single_bus ? dma_word_bus_in[7:0] :
        processor_addr_data_port_in;

    // ----------------------------------------------------------------
    // Read data and parity for the DMA word bus
    // ----------------------------------------------------------------
    reg [15:0] db_d;
    reg [1:0] db_oe_d;
    wire [1:0] par_d;

    always @* begin
        db_d = `HDBI_RST_WORD;
        db_oe_d = `HDBI_LANES_NONE;
        if (dma_rd_now) begin
            db_d = fifo_rdata;
            db_oe_d = lanes_now;
        end else if (single_bus && reg_rd_now) begin
            db_d = {8'h00, reg_rdata};
            db_oe_d = `HDBI_LANES_LOW;
        end
    end

    hdbi_lane_parity u_lane_parity (
        .data(db_d),
        .odd_par(par_d)
    );

    // ----------------------------------------------------------------
    // Access tracking state
    // ----------------------------------------------------------------
    reg reg_wr_act_q;
    reg reg_rd_seen_q;
    reg dma_wr_act_q;
    reg dma_rd_act_q;
    reg [3:0] wcap_addr_q;
    reg [7:0] wcap_data_q;
    reg [15:0] dcap_data_q;
    reg [1:0] dcap_par_q;
    reg [1:0] dcap_lanes_q;
    reg [1:0] rcap_lanes_q;
    reg int_pend_q;

    wire reg_wr_done;
    wire reg_rd_start;
    wire dma_wr_done;
    wire dma_rd_done;
    wire int_clear;

    assign reg_wr_done = reg_wr_act_q & ~reg_wr_now;
    // A read start waits one cycle if a write commit occupies the port
    assign reg_rd_start = reg_rd_now & ~reg_rd_seen_q & ~reg_wr_done;
    assign dma_wr_done = dma_wr_act_q & ~dma_wr_now;
    assign dma_rd_done = dma_rd_act_q & ~dma_rd_now;
    assign int_clear = (reg_rd_start && addr_now == `HDBI_INT_STATUS_ADDR) ||
        sw_chip_reset;

    // ----------------------------------------------------------------
    // Strobe capture: data held while the strobe is low
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_wr_act_q <= 1'b0;
            reg_rd_seen_q <= 1'b0;
            dma_wr_act_q <= 1'b0;
            dma_rd_act_q <= 1'b0;
            wcap_addr_q <= `HDBI_RST_ADDR;
            wcap_data_q <= `HDBI_RST_BYTE;
            dcap_data_q <= `HDBI_RST_WORD;
            dcap_par_q <= `HDBI_LANES_NONE;
            dcap_lanes_q <= `HDBI_LANES_NONE;
            rcap_lanes_q <= `HDBI_LANES_NONE;
        end else begin
            reg_wr_act_q <= reg_wr_now;
            dma_wr_act_q <= dma_wr_now;
            dma_rd_act_q <= dma_rd_now;
            if (!reg_rd_now) begin
                reg_rd_seen_q <= 1'b0;
            end else if (reg_rd_start) begin
                reg_rd_seen_q <= 1'b1;
            end
            if (reg_wr_now) begin
                wcap_addr_q <= addr_now;
                wcap_data_q <= reg_bus_in;
            end
            if (dma_wr_now) begin
                dcap_data_q <= dma_word_bus_in;
                dcap_par_q <= {upper_lane_parity_in, lower_lane_parity_in};
                dcap_lanes_q <= lanes_now;
            end
            if (dma_rd_now) begin
                rcap_lanes_q <= lanes_now;
            end
        end
    end

    // ----------------------------------------------------------------
    // Core side requests
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_addr <= `HDBI_RST_ADDR;
            reg_wr_pulse <= 1'b0;
            reg_wdata <= `HDBI_RST_BYTE;
            reg_rd_pulse <= 1'b0;
            fifo_wr_pulse <= 1'b0;
            fifo_wdata <= `HDBI_RST_WORD;
            fifo_wpar <= `HDBI_LANES_NONE;
            fifo_lanes <= `HDBI_LANES_NONE;
            fifo_rd_pulse <= 1'b0;
        end else begin
            reg_wr_pulse <= 1'b0;
            reg_rd_pulse <= 1'b0;
            fifo_wr_pulse <= 1'b0;
            fifo_rd_pulse <= 1'b0;
            if (reg_wr_done) begin
                reg_addr <= wcap_addr_q;
                reg_wdata <= wcap_data_q;
                reg_wr_pulse <= 1'b1;
            end else if (reg_rd_start) begin
                reg_addr <= addr_now;
                reg_rd_pulse <= 1'b1;
            end
            if (dma_wr_done && dcap_lanes_q != `HDBI_LANES_NONE) begin
                fifo_wdata <= dcap_data_q;
                fifo_wpar <= dcap_par_q;
                fifo_lanes <= dcap_lanes_q;
                fifo_wr_pulse <= 1'b1;
            end else if (dma_rd_done && rcap_lanes_q != `HDBI_LANES_NONE) begin
                fifo_lanes <= rcap_lanes_q;
                fifo_rd_pulse <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus drivers
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            processor_addr_data_port_out <= `HDBI_RST_BYTE;
            processor_addr_data_port_oe <= 1'b0;
            dma_word_bus_out <= `HDBI_RST_WORD;
            dma_word_bus_oe <= `HDBI_LANES_NONE;
            upper_lane_parity_out <= 1'b0;
            lower_lane_parity_out <= 1'b0;
            upper_lane_parity_oe <= 1'b0;
            lower_lane_parity_oe <= 1'b0;
        end else begin
            processor_addr_data_port_out <= reg_rdata;
            processor_addr_data_port_oe <= cfg_dual_bus & reg_rd_now;
            dma_word_bus_out <= db_d;
            dma_word_bus_oe <= db_oe_d;
            upper_lane_parity_out <= par_d[1];
            lower_lane_parity_out <= par_d[0];
            upper_lane_parity_oe <= db_oe_d[1];
            lower_lane_parity_oe <= db_oe_d[0];
        end
    end

    // ----------------------------------------------------------------
    // DMA request and interrupt
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dma_request <= 1'b0;
            int_pend_q <= 1'b0;
            interrupt_n_out <= 1'b0;
            interrupt_n_oe <= 1'b0;
        end else begin
            dma_request <= dma_dir_to_host ? fifo_has_unit : fifo_has_room;
            // A new event wins over a clear in the same cycle
            int_pend_q <= int_event | (int_pend_q & ~int_clear);
            interrupt_n_out <= 1'b0;
            // Open drain: pull low while pending, no mask on the path
            interrupt_n_oe <= int_event | (int_pend_q & ~int_clear);
        end
    end

endmodule // hdbi_host_port

/* tb/hdbi_far_side.sv */
// Far-side model: host bus lines with pull-ups and core register and FIFO data
`timescale 1ns/10ps
module hdbi_far_side (
    input wire [3:0] reg_addr,
    input wire [7:0] pad_out,
    input wire pad_oe,
    input wire [7:0] host_pad,
    input wire host_pad_en,
    input wire [15:0] db_out,
    input wire [1:0] db_oe,
    input wire [15:0] host_db,
    input wire host_db_en,
    output wire [7:0] pad_line,
    output wire [15:0] db_line,
    output wire [7:0] reg_rdata,
    output wire [15:0] fifo_rdata
);
    // ----------------------------------------------------------------
    // Wire levels
    // ----------------------------------------------------------------
    // Released lines float high through the internal pull-ups
    assign pad_line = pad_oe ? pad_out : (host_pad_en ? host_pad : 8'hff);
    assign db_line[15:8] = db_oe[1] ? db_out[15:8] : (host_db_en ? host_db[15:8] : 8'hff);
    assign db_line[7:0] = db_oe[0] ? db_out[7:0] : (host_db_en ? host_db[7:0] : 8'hff);
    // Each register answers with its own address so a wrong decode shows
    assign reg_rdata = {4'hc, reg_addr};
    assign fifo_rdata = 16'hb3c5;
endmodule // hdbi_far_side

/* tb/hdbi_host_port_props.sv */
// Concurrent checks on the host and DMA bus port
`timescale 1ns/10ps
module hdbi_host_port_props (
    input wire clk,
    input wire rstn,
    input wire chip_select_n,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire dma_acknowledge_n,
    input wire dma_write_strobe_n,
    input wire dma_dir_to_host,
    input wire fifo_has_unit,
    input wire fifo_has_room,
    input wire int_event,
    input wire sw_chip_reset,
    input wire processor_addr_data_port_oe,
    input wire [1:0] dma_word_bus_oe,
    input wire [15:0] dma_word_bus_out,
    input wire upper_lane_parity_out,
    input wire lower_lane_parity_out,
    input wire upper_lane_parity_oe,
    input wire lower_lane_parity_oe,
    input wire dma_request,
    input wire interrupt_n_oe,
    input wire reg_wr_pulse,
    input wire fifo_wr_pulse,
    input wire [1:0] fifo_lanes
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_PAD_OE: assert property ($rose(processor_addr_data_port_oe) |->
        $past(!chip_select_n && !read_strobe_n)) else $error("pad driven without read");
    AST_DB_OE: assert property ($rose(|dma_word_bus_oe) |->
        $past(!chip_select_n || !dma_acknowledge_n)) else $error("bus driven unselected");
    AST_PAR_HI: assert property (upper_lane_parity_oe |->
        upper_lane_parity_out == ~^dma_word_bus_out[15:8]) else $error("upper parity wrong");
    AST_PAR_LO: assert property (lower_lane_parity_oe |->
        lower_lane_parity_out == ~^dma_word_bus_out[7:0]) else $error("lower parity wrong");
    AST_PAR_OE: assert property ((upper_lane_parity_oe == dma_word_bus_oe[1]) &&
        (lower_lane_parity_oe == dma_word_bus_oe[0])) else $error("parity enable mismatch");
    AST_INT_SET: assert property (int_event |=> interrupt_n_oe)
        else $error("interrupt not raised");
    AST_INT_RISE: assert property ($rose(interrupt_n_oe) |-> $past(int_event))
        else $error("interrupt raised without event");
    AST_INT_SW: assert property (sw_chip_reset && !int_event |=> !interrupt_n_oe)
        else $error("software reset left interrupt");
    AST_REG_WR: assert property (reg_wr_pulse |->
        $past(!chip_select_n && !write_strobe_n, 2)) else $error("stray register write");
    AST_FIFO_WR: assert property (fifo_wr_pulse |-> fifo_lanes != 2'h0 &&
        $past(!dma_acknowledge_n && !dma_write_strobe_n, 2)) else $error("stray FIFO write");
    AST_REQ: assert property ($past(rstn) |-> dma_request ==
        $past(dma_dir_to_host ? fifo_has_unit : fifo_has_room)) else $error("request wrong");
    cover property (reg_wr_pulse);
    cover property (fifo_wr_pulse && fifo_lanes == 2'h3);
    cover property ($fell(interrupt_n_oe));
endmodule // hdbi_host_port_props

bind hdbi_host_port hdbi_host_port_props chk_u (.*);

/* tb/hdbi_host_port_bench.sv */
// Self-checking bench for the host and DMA bus port
`timescale 1ns/10ps
module hdbi_host_port_bench;
    // ----------------------------------------------------------------
    // Wiring
    // ----------------------------------------------------------------
    reg clk = 1'b0, rstn = 1'b0, cfg_dual_bus = 1'b1, cfg_mux_mode = 1'b0;
    reg cfg_host_mode2 = 1'b0, cfg_byte_ctrl = 1'b0, dma_dir_to_host = 1'b0;
    reg fifo_has_unit = 1'b0, fifo_has_room = 1'b0, int_event = 1'b0, sw_chip_reset = 1'b0;
    reg addr3_or_latch_strobe_pin = 1'b0, addr2_or_dma_read_pin = 1'b1;
    reg addr1_or_high_enable_pin = 1'b0, addr0_or_low_select_pin = 1'b0;
    reg chip_select_n = 1'b1, read_strobe_n = 1'b1, write_strobe_n = 1'b1;
    reg dma_acknowledge_n = 1'b1, dma_write_strobe_n = 1'b1, h_pad_en = 1'b0, h_db_en = 1'b0;
    reg upper_lane_parity_in = 1'b0, lower_lane_parity_in = 1'b0;
    reg [7:0] h_pad = 8'h00;
    reg [15:0] h_db = 16'h0000;
    wire [7:0] processor_addr_data_port_in, processor_addr_data_port_out, reg_wdata, reg_rdata;
    wire [15:0] dma_word_bus_in, dma_word_bus_out, fifo_wdata, fifo_rdata;
    wire [1:0] dma_word_bus_oe, fifo_wpar, fifo_lanes;
    wire [3:0] reg_addr;
    wire processor_addr_data_port_oe, upper_lane_parity_out, lower_lane_parity_out;
    wire upper_lane_parity_oe, lower_lane_parity_oe, dma_request, interrupt_n_out, interrupt_n_oe;
    wire reg_wr_pulse, reg_rd_pulse, fifo_wr_pulse, fifo_rd_pulse;
    integer num_errors = 0, check_count = 0;
    hdbi_host_port dut_u (.*);
    hdbi_far_side far_u (.reg_addr(reg_addr), .pad_out(processor_addr_data_port_out),
        .pad_oe(processor_addr_data_port_oe), .host_pad(h_pad), .host_pad_en(h_pad_en),
        .db_out(dma_word_bus_out), .db_oe(dma_word_bus_oe), .host_db(h_db), .host_db_en(h_db_en),
        .pad_line(processor_addr_data_port_in), .db_line(dma_word_bus_in),
        .reg_rdata(reg_rdata), .fifo_rdata(fifo_rdata));
    always #12.5 clk = ~clk;
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task nc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task chk(input [16:0] seen, input [16:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("errors %0d checks %0d", num_errors, check_count);
            if (num_errors == 0 && check_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task dma_wr(input [15:0] d);
        begin
            {h_db, h_db_en, dma_acknowledge_n, dma_write_strobe_n} = {d, 3'b100};
            nc(1);
            {h_db_en, dma_acknowledge_n, dma_write_strobe_n} = 3'b011;
            nc(1);
        end
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_write;
        begin
            {addr3_or_latch_strobe_pin, addr2_or_dma_read_pin} = 2'b10;
            {addr1_or_high_enable_pin, addr0_or_low_select_pin, h_pad, h_pad_en} = {10'h15a, 1'b1};
            {chip_select_n, write_strobe_n, dma_acknowledge_n, read_strobe_n} = 4'b0001;
            nc(1);
            {chip_select_n, write_strobe_n, h_pad_en} = 3'b110;
            nc(1);
            chk({reg_wr_pulse, processor_addr_data_port_oe}, 2'b10);
            chk({reg_addr, reg_wdata}, 12'h95a);
            {dma_acknowledge_n, read_strobe_n} = 2'b11;
            nc(1);
            chk(reg_wr_pulse, 1'b0);
        end
    endtask
    task t_int_read;
        begin
            {cfg_mux_mode, addr3_or_latch_strobe_pin, addr2_or_dma_read_pin} = 3'b111;
            {h_pad, h_pad_en, int_event} = {8'h05, 2'b11};
            nc(2);
            {addr3_or_latch_strobe_pin, int_event} = 2'b00;
            nc(2);
            chk(interrupt_n_oe, 1'b1);
            {h_pad_en, chip_select_n, read_strobe_n} = 3'b000;
            nc(1);
            chk(reg_addr, 4'h5);
            chk({reg_rd_pulse, processor_addr_data_port_oe, interrupt_n_oe}, 3'b110);
            nc(1);
            chk(processor_addr_data_port_in, 8'hc5);
            {chip_select_n, read_strobe_n} = 2'b11;
            nc(2);
            chk(processor_addr_data_port_in, 8'hff);
        end
    endtask
    task t_lanes;
        integer k;
        reg [9:0] tab;
        begin
            tab = 10'b1110110001;
            {cfg_host_mode2, cfg_byte_ctrl, upper_lane_parity_in} = 3'b111;
            {addr3_or_latch_strobe_pin, addr2_or_dma_read_pin} = 2'b01;
            for (k = 0; k < 5; k = k + 1) begin
                {addr1_or_high_enable_pin, addr0_or_low_select_pin} = (k == 4) ? 2'b01 : k[1:0];
                cfg_host_mode2 = (k != 4);
                dma_wr(16'h1234 + k[15:0]);
                chk(fifo_wr_pulse, k != 1);
                if (k != 1) chk(fifo_wdata, 16'h1234 + k[15:0]);
                if (k != 1) chk({fifo_lanes, fifo_wpar}, {tab[2*k +: 2], 2'b10});
                nc(1);
            end
            // Multiplexed DMA read on the upper lane only
            {cfg_host_mode2, addr1_or_high_enable_pin, addr0_or_low_select_pin} = 3'b111;
            {dma_acknowledge_n, addr2_or_dma_read_pin} = 2'b00;
            nc(2);
            chk({dma_word_bus_oe, upper_lane_parity_oe, lower_lane_parity_oe}, 4'ha);
            chk(dma_word_bus_in, 16'hb3ff);
            {dma_acknowledge_n, addr2_or_dma_read_pin} = 2'b11;
            nc(1);
            chk({fifo_rd_pulse, fifo_lanes}, 3'b110);
        end
    endtask
    task t_dma_read;
        begin
            {cfg_dual_bus, cfg_mux_mode, cfg_byte_ctrl, addr3_or_latch_strobe_pin} = 4'h0;
            {addr2_or_dma_read_pin, addr1_or_high_enable_pin, addr0_or_low_select_pin} = 3'b111;
            {chip_select_n, read_strobe_n} = 2'b00;
            nc(2);
            chk({processor_addr_data_port_oe, dma_word_bus_in[7:0]}, 9'h0c7);
            {chip_select_n, read_strobe_n} = 2'b11;
            nc(2);
            {dma_acknowledge_n, read_strobe_n} = 2'b00;
            nc(2);
            chk(dma_word_bus_in, 16'hb3c5);
            chk({upper_lane_parity_oe, lower_lane_parity_oe, dma_word_bus_oe}, 4'hf);
            chk({upper_lane_parity_out, lower_lane_parity_out}, {~^8'hb3, ~^8'hc5});
            {dma_acknowledge_n, read_strobe_n} = 2'b11;
            nc(1);
            chk({fifo_rd_pulse, dma_word_bus_in}, 17'h1ffff);
        end
    endtask
    task t_req;
        integer k;
        for (k = 0; k < 8; k = k + 1) begin
            {dma_dir_to_host, fifo_has_unit, fifo_has_room} = k[2:0];
            nc(2);
            chk(dma_request, k[2] ? k[1] : k[0]);
        end
    endtask
    task t_resets;
        begin
            int_event = 1'b1;
            nc(1);
            chk({interrupt_n_out, interrupt_n_oe}, 2'b01);
            {int_event, sw_chip_reset} = 2'b01;
            nc(1);
            sw_chip_reset = 1'b0;
            chk(interrupt_n_oe, 1'b0);
            int_event = 1'b1;
            nc(2);
            {rstn, int_event} = 2'b00;
            #1;
            chk(interrupt_n_oe, 1'b0);
            nc(2);
            rstn = 1'b1;
            nc(1);
        end
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        nc(5);
        rstn = 1'b1;
        nc(1);
        t_write;
        t_int_read;
        t_lanes;
        t_dma_read;
        t_req;
        t_resets;
        wrap_up;
    end
    initial begin
        #(25 * 400);
        num_errors = num_errors + 1;
        wrap_up;
    end
endmodule // hdbi_host_port_bench
